// ---- include/dpa_consts.vh ----
// Field positions, codes and reset values of the data-processing datapath
// Operation
// - Register form: second source register in bits 3..0, shift control in 11..4.
// - Literal form: bits 7..0 are an 8-bit constant, bits 11..8 its rotate.
// - First operand always comes from the first operand register field.
// - Literal-select bit picks shifted register or rotated literal as operand two.
// - Flags change only when the set-flags bit is one or the operation is a test or compare.
// - Test and compare operations never write the destination; they always set flags.
// - Flag-setting logical operations keep the overflow flag.
// - Logical operations take shifter carry; left shift by zero keeps old carry.
// - Logical operations: zero flag when result is zero, negative copies bit 31.
// - Opcode 0100 adds; 0101 adds plus the carry flag.
// - Opcode 0010 subtracts second from first; 0110 also subtracts inverted carry.
// - Opcode 0011 subtracts first from second; 0111 also subtracts inverted carry.
// - Opcodes 0000 AND, 0001 XOR, 1100 OR, 1110 first AND NOT second.
// - Opcode 1101 passes operand two, 1111 its complement; operand one ignored.
// - Opcodes 1000..1011 act as AND, XOR, subtract, add without writing result.
// - Arithmetic overflow flag marks signed overflow into result bit 31.
// - Arithmetic carry flag takes the adder carry out of bit 31.
// - Arithmetic: zero flag when result is zero, negative equals bit 31.
// - Shift kinds left, right, arithmetic right, rotate; amount literal or register byte.
// - Instruction only takes effect when its condition passes.
// - Instruction bit 25 selects a literal second operand.
// - Instruction bit 20 requests a flag update.
// - Destination program counter with set-flags copies saved status into status word.
`ifndef DPA_CONSTS_VH
`define DPA_CONSTS_VH
`define DPA_F_IMM        25
`define DPA_F_OPC_HI     24
`define DPA_F_OPC_LO     21
`define DPA_F_SET        20
`define DPA_F_RN_HI      19
`define DPA_F_RN_LO      16
`define DPA_F_RD_HI      15
`define DPA_F_RD_LO      12
`define DPA_F_RS_HI      11
`define DPA_F_RS_LO      8
`define DPA_F_SAMT_HI    11
`define DPA_F_SAMT_LO    7
`define DPA_F_STYP_HI    6
`define DPA_F_STYP_LO    5
`define DPA_F_SREG       4
`define DPA_F_RM_HI      3
`define DPA_F_RM_LO      0
`define DPA_F_ROT_HI     11
`define DPA_F_ROT_LO     8
`define DPA_F_LIT_HI     7
`define DPA_F_LIT_LO     0
`define DPA_OP_AND       4'h0
`define DPA_OP_XOR       4'h1
`define DPA_OP_SUB       4'h2
`define DPA_OP_RSUB      4'h3
`define DPA_OP_ADD       4'h4
`define DPA_OP_ADDC      4'h5
`define DPA_OP_SUBC      4'h6
`define DPA_OP_RSUBC     4'h7
`define DPA_OP_TAND      4'h8
`define DPA_OP_TXOR      4'h9
`define DPA_OP_CMPS      4'hA
`define DPA_OP_CMPA      4'hB
`define DPA_OP_OR        4'hC
`define DPA_OP_COPY      4'hD
`define DPA_OP_CLEAR     4'hE
`define DPA_OP_NOT       4'hF
`define DPA_SH_LSL       2'h0
`define DPA_SH_LSR       2'h1
`define DPA_SH_ASR       2'h2
`define DPA_SH_ROR       2'h3
`define DPA_PSW_N        31
`define DPA_PSW_Z        30
`define DPA_PSW_C        29
`define DPA_PSW_V        28
`define DPA_PSW_RESET    32'h00000000
`define DPA_PC_INDEX     4'hF
`endif

// ---- core/dpa_regfile.v ----
// Sixteen-word register file with two registered read ports
`timescale 1ns/1ps
`default_nettype none
module dpa_regfile (
   input  wire        clk_in,
   input  wire        wr_en_in,
   input  wire [3:0]  wr_addr_in,
   input  wire [31:0] wr_data_in,
   input  wire [3:0]  rd_addr_a_in,
   input  wire [3:0]  rd_addr_b_in,
   output reg  [31:0] rd_data_a_out,
   output reg  [31:0] rd_data_b_out
);
   reg [31:0] mem [0:15];

   // Write and read; a read in the write cycle returns the old word
   always @(posedge clk_in)
   begin
      if (wr_en_in)
      begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_a_out <= mem[rd_addr_a_in];
      rd_data_b_out <= mem[rd_addr_b_in];
   end
endmodule // dpa_regfile
`default_nettype wire

// ---- core/dpa_shifter.v ----
// Barrel shifter for the second operand, with carry out
`timescale 1ns/1ps
`default_nettype none
`include "dpa_consts.vh"
module dpa_shifter (
   input  wire [31:0] value_in,
   input  wire [1:0]  type_in,
   input  wire [7:0]  amount_in,
   input  wire        literal_amt_in,
   input  wire        carry_in,
   output reg  [31:0] result_out,
   output reg         carry_out
);
   reg [7:0]  amt;
   reg        rrx;
   reg [63:0] left_wide;
   reg [63:0] right_wide;
   reg [63:0] arith_wide;
   reg [63:0] rot_wide;

   // Shift by amount; amount zero passes value and old carry
   always @*
   begin
      amt = amount_in;
      rrx = 1'b0;
      // Literal zero encodes 32 for right shifts, extended rotate for rotate
      if (literal_amt_in && amount_in == 8'h00)
      begin
         if (type_in == `DPA_SH_LSR || type_in == `DPA_SH_ASR)
            amt = 8'h20;
         else if (type_in == `DPA_SH_ROR)
            rrx = 1'b1;
      end
      left_wide  = {32'h00000000, value_in} << amt[4:0];
      right_wide = {value_in, 32'h00000000} >> amt[4:0];
      arith_wide = $signed({value_in, 32'h00000000}) >>> amt[4:0];
      rot_wide   = {value_in, value_in} >> amt[4:0];
      result_out = value_in;
      carry_out  = carry_in;
      if (rrx)
      begin
         result_out = {carry_in, value_in[31:1]};
         carry_out  = value_in[0];
      end
      else if (amt != 8'h00)
      begin
         case (type_in)
            `DPA_SH_LSL:
            begin
               result_out = (amt < 8'h20) ? left_wide[31:0] : 32'h00000000;
               carry_out  = (amt < 8'h20) ? left_wide[32] :
                            (amt == 8'h20) ? value_in[0] : 1'b0;
            end
            `DPA_SH_LSR:
            begin
               result_out = (amt < 8'h20) ? right_wide[63:32] : 32'h00000000;
               carry_out  = (amt < 8'h20) ? right_wide[31] :
                            (amt == 8'h20) ? value_in[31] : 1'b0;
            end
            `DPA_SH_ASR:
            begin
               result_out = (amt < 8'h20) ? arith_wide[63:32] : {32{value_in[31]}};
               carry_out  = (amt < 8'h20) ? arith_wide[31] : value_in[31];
            end
            default:
            begin
               result_out = rot_wide[31:0];
               carry_out  = rot_wide[31];
            end
         endcase
      end
   end
endmodule // dpa_shifter
`default_nettype wire

// ---- core/dpa_datapath.v ----
// Data-processing execution path: operand decode, ALU, flags, write-back
`timescale 1ns/1ps
`default_nettype none
`include "dpa_consts.vh"
module dpa_datapath (
   input  wire        clk_in,
   input  wire        reset_n_in,
   input  wire        instr_valid_in,
   input  wire [31:0] instr_in,
   input  wire        cond_pass_in,
   input  wire [31:0] saved_status_word_in,
   input  wire        load_en_in,
   input  wire [3:0]  load_index_in,
   input  wire [31:0] load_data_in,
   output wire        instr_ready_out,
   output reg         done_out,
   output reg  [31:0] result_out,
   output reg         result_write_out,
   output reg  [3:0]  result_index_out,
   output reg         pc_write_out,
   output wire [31:0] program_status_word_out
);
   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_FETCH  = 2'h1;
   localparam [1:0] ST_AMOUNT = 2'h2;
   localparam [1:0] ST_EXEC   = 2'h3;

   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [31:0] instr;
   reg         cond_pass;
   reg  [31:0] op1;
   reg  [31:0] op2_raw;
   reg  [7:0]  shift_amount;
   reg  [31:0] program_status_word;
   reg  [31:0] next_psw;

   wire [3:0]  opcode;
   wire [3:0]  rd_index;
   wire        set_bit;
   wire        imm_sel;
   wire        reg_shift;
   wire [31:0] rd_data_a;
   wire [31:0] rd_data_b;
   reg  [3:0]  rd_addr_a;
   wire [3:0]  rd_addr_b;

   wire [31:0] sh_value;
   wire [1:0]  sh_type;
   wire [7:0]  sh_amount;
   wire        sh_literal;
   wire [31:0] op2;
   wire        sh_carry;

   reg  [31:0] add_a;
   reg  [31:0] add_b;
   reg         add_cin;
   wire [32:0] sum;
   wire        overflow;
   reg  [31:0] logic_res;
   wire [31:0] alu_result;
   wire        logical;
   wire        test_op;
   wire        flag_n;
   wire        flag_z;
   wire        flag_c;
   wire        flag_v;

   wire        exec_live;
   wire        writes_dest;
   wire        flag_update;
   wire        restore_psw;
   wire        rf_wr_en;
   wire [3:0]  rf_wr_addr;
   wire [31:0] rf_wr_data;
   wire        dest_write;
   wire        dest_is_pc;

   // True for the eight logical-class opcodes
   function is_logical;
      input [3:0] op;
      begin
         is_logical = (op == `DPA_OP_AND)  || (op == `DPA_OP_XOR)  ||
                      (op == `DPA_OP_TAND) || (op == `DPA_OP_TXOR) ||
                      (op == `DPA_OP_OR)   || (op == `DPA_OP_COPY) ||
                      (op == `DPA_OP_CLEAR) || (op == `DPA_OP_NOT);
      end
   endfunction

   // True when a register index names the program counter
   function is_pc;
      input [3:0] idx;
      begin
         is_pc = (idx == `DPA_PC_INDEX);
      end
   endfunction

   // True for the four test and compare opcodes
   function is_test;
      input [3:0] op;
      begin
         is_test = (op[3:2] == 2'b10);
      end
   endfunction

   // Instruction field decode
   assign opcode    = instr[`DPA_F_OPC_HI:`DPA_F_OPC_LO];
   assign rd_index  = instr[`DPA_F_RD_HI:`DPA_F_RD_LO];
   assign set_bit   = instr[`DPA_F_SET];
   assign imm_sel   = instr[`DPA_F_IMM];
   assign reg_shift = instr[`DPA_F_SREG];
   assign logical   = is_logical(opcode);
   assign test_op   = is_test(opcode);

   // One request at a time
   assign instr_ready_out = (state == ST_IDLE);

   // Sequencer: fetch operands, optionally the shift amount, then execute
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (instr_valid_in)
               next_state = ST_FETCH;
         end
         ST_FETCH:
         begin
            if (!imm_sel && reg_shift)
               next_state = ST_AMOUNT;
            else
               next_state = ST_EXEC;
         end
         ST_AMOUNT:
         begin
            next_state = ST_EXEC;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Read addresses: first operand and second source, then shift register
   always @*
   begin
      if (state == ST_FETCH)
         rd_addr_a = instr[`DPA_F_RS_HI:`DPA_F_RS_LO];
      else
         rd_addr_a = instr_in[`DPA_F_RN_HI:`DPA_F_RN_LO];
   end
   assign rd_addr_b = instr_in[`DPA_F_RM_HI:`DPA_F_RM_LO];

   // State, instruction latch and operand capture
   always @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state        <= ST_IDLE;
         instr        <= 32'h00000000;
         cond_pass    <= 1'b0;
         op1          <= 32'h00000000;
         op2_raw      <= 32'h00000000;
         shift_amount <= 8'h00;
      end
      else
      begin
         state <= next_state;
         if (state == ST_IDLE && instr_valid_in)
         begin
            instr     <= instr_in;
            cond_pass <= cond_pass_in;
         end
         if (state == ST_FETCH)
         begin
            op1     <= rd_data_a;
            op2_raw <= rd_data_b;
         end
         if (state == ST_AMOUNT)
            shift_amount <= rd_data_a[7:0];
      end
   end

   // Shifter inputs: rotated literal or shifted register
   assign sh_value   = imm_sel ? {24'h000000, instr[`DPA_F_LIT_HI:`DPA_F_LIT_LO]}
                               : op2_raw;
   assign sh_type    = imm_sel ? `DPA_SH_ROR
                               : instr[`DPA_F_STYP_HI:`DPA_F_STYP_LO];
   assign sh_amount  = imm_sel ? {3'h0, instr[`DPA_F_ROT_HI:`DPA_F_ROT_LO], 1'b0}
                               : reg_shift ? shift_amount
                               : {3'h0, instr[`DPA_F_SAMT_HI:`DPA_F_SAMT_LO]};
   assign sh_literal = !imm_sel && !reg_shift;

   dpa_shifter u_shifter (
      .value_in       (sh_value),
      .type_in        (sh_type),
      .amount_in      (sh_amount),
      .literal_amt_in (sh_literal),
      .carry_in       (program_status_word[`DPA_PSW_C]),
      .result_out     (op2),
      .carry_out      (sh_carry)
   );

   // Adder operand steering; subtraction adds the inverted operand
   always @*
   begin
      add_a   = op1;
      add_b   = op2;
      add_cin = 1'b0;
      case (opcode)
         `DPA_OP_SUB, `DPA_OP_CMPS:
         begin
            add_b   = ~op2;
            add_cin = 1'b1;
         end
         `DPA_OP_SUBC:
         begin
            add_b   = ~op2;
            add_cin = program_status_word[`DPA_PSW_C];
         end
         `DPA_OP_RSUB:
         begin
            add_a   = op2;
            add_b   = ~op1;
            add_cin = 1'b1;
         end
         `DPA_OP_RSUBC:
         begin
            add_a   = op2;
            add_b   = ~op1;
            add_cin = program_status_word[`DPA_PSW_C];
         end
         `DPA_OP_ADDC:
         begin
            add_cin = program_status_word[`DPA_PSW_C];
         end
         default:
         begin
            add_cin = 1'b0;
         end
      endcase
   end

   // 32-bit adder with carry out of bit 31
   assign sum = {1'b0, add_a} + {1'b0, add_b} + {32'h00000000, add_cin};
   assign overflow = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);

   // Bitwise operations
   always @*
   begin
      case (opcode)
         `DPA_OP_AND, `DPA_OP_TAND: logic_res = op1 & op2;
         `DPA_OP_XOR, `DPA_OP_TXOR: logic_res = op1 ^ op2;
         `DPA_OP_OR:                logic_res = op1 | op2;
         `DPA_OP_CLEAR:             logic_res = op1 & ~op2;
         `DPA_OP_COPY:              logic_res = op2;
         `DPA_OP_NOT:               logic_res = ~op2;
         default:                   logic_res = 32'h00000000;
      endcase
   end

   assign alu_result = logical ? logic_res : sum[31:0];

   // Condition flags from the result
   assign flag_n = alu_result[31];
   assign flag_z = (alu_result == 32'h00000000);
   assign flag_c = logical ? sh_carry : sum[32];
   assign flag_v = logical ? program_status_word[`DPA_PSW_V]
                           : overflow;

   // Effects of an executed instruction
   assign exec_live   = (state == ST_EXEC) && cond_pass;
   assign writes_dest = !test_op;
   assign flag_update = set_bit || test_op;
   assign restore_psw = writes_dest && set_bit && dest_is_pc;
   // Destination write of a live instruction, program counter destination
   assign dest_write  = exec_live && writes_dest;
   assign dest_is_pc  = is_pc(rd_index);

   // Status word next value
   always @*
   begin
      next_psw = program_status_word;
      if (exec_live)
      begin
         if (restore_psw)
            next_psw = saved_status_word_in;
         else if (flag_update)
         begin
            next_psw[`DPA_PSW_N] = flag_n;
            next_psw[`DPA_PSW_Z] = flag_z;
            next_psw[`DPA_PSW_C] = flag_c;
            next_psw[`DPA_PSW_V] = flag_v;
         end
      end
   end

   // Register file write: execution has priority over external loads
   assign rf_wr_en   = dest_write || load_en_in;
   assign rf_wr_addr = dest_write ? rd_index : load_index_in;
   assign rf_wr_data = dest_write ? alu_result : load_data_in;

   dpa_regfile u_regfile (
      .clk_in        (clk_in),
      .wr_en_in      (rf_wr_en),
      .wr_addr_in    (rf_wr_addr),
      .wr_data_in    (rf_wr_data),
      .rd_addr_a_in  (rd_addr_a),
      .rd_addr_b_in  (rd_addr_b),
      .rd_data_a_out (rd_data_a),
      .rd_data_b_out (rd_data_b)
   );

   // Status word and registered result outputs
   always @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         program_status_word <= `DPA_PSW_RESET;
         done_out            <= 1'b0;
         result_out          <= 32'h00000000;
         result_write_out    <= 1'b0;
         result_index_out    <= 4'h0;
         pc_write_out        <= 1'b0;
      end
      else
      begin
         program_status_word <= next_psw;
         done_out            <= (state == ST_EXEC);
         result_write_out    <= dest_write;
         pc_write_out        <= dest_write && dest_is_pc;
         if (state == ST_EXEC)
         begin
            result_out       <= alu_result;
            result_index_out <= rd_index;
         end
      end
   end

   assign program_status_word_out = program_status_word;

endmodule // dpa_datapath
`default_nettype wire

// ---- test/dpa_datapath_props.sv ----
// Port-level assertions for the data-processing datapath
`timescale 1ns/1ps
`default_nettype none
module dpa_datapath_props (
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic        instr_valid_in,
   input wire logic [31:0] instr_in,
   input wire logic        cond_pass_in,
   input wire logic        instr_ready_out,
   input wire logic        done_out,
   input wire logic        result_write_out,
   input wire logic [3:0]  result_index_out,
   input wire logic        pc_write_out,
   input wire logic [31:0] program_status_word_out
);
   default clocking dpa_cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // Request taken, register-shift form and test class
   wire take  = instr_valid_in && instr_ready_out;
   wire regsh = !instr_in[25] && instr_in[4];
   wire tst   = instr_in[24:23] == 2'h2;
   a_take_busy: assert property (take |=> !instr_ready_out)
      else $error("ready stayed high after a take");
   a_lit_latency: assert property (take && !regsh |=> !done_out [*2] ##1 done_out)
      else $error("literal form done not after three cycles");
   a_regsh_latency: assert property (take && regsh |=> !done_out [*3] ##1 done_out)
      else $error("register shift done not after four cycles");
   a_write_in_done: assert property ((result_write_out || pc_write_out) |-> done_out)
      else $error("write pulse outside done");
   a_pc_index: assert property (pc_write_out |->
      result_write_out && result_index_out == 4'hF)
      else $error("program counter write with wrong index");
   a_test_nowrite: assert property (take && tst |->
      ##[3:4] (done_out && !result_write_out))
      else $error("test operation wrote a register");
   a_cond_quiet: assert property (take && !cond_pass_in |->
      ##[3:4] (done_out && !result_write_out && $stable(program_status_word_out)))
      else $error("failed condition had an effect");
   a_psw_at_done: assert property (!done_out |-> $stable(program_status_word_out))
      else $error("status word changed outside done");
   a_s_clear_keep: assert property (take && !instr_in[20] && !tst |->
      ##[3:4] (done_out && $stable(program_status_word_out)))
      else $error("flags changed with set-flags clear");
endmodule // dpa_datapath_props
bind dpa_datapath dpa_datapath_props i_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .instr_valid_in(instr_valid_in), .instr_in(instr_in), .cond_pass_in(cond_pass_in),
   .instr_ready_out(instr_ready_out), .done_out(done_out), .result_write_out(result_write_out),
   .result_index_out(result_index_out), .pc_write_out(pc_write_out),
   .program_status_word_out(program_status_word_out));
`default_nettype wire

// ---- test/dpa_datapath_tb_top.sv ----
// Self-checking bench for the data-processing datapath
`timescale 1ns/1ps
`default_nettype none
`include "dpa_consts.vh"
module dpa_datapath_tb_top;
   typedef struct packed {logic [31:0] res; logic wr; logic [3:0] idx;
                          logic pcw; logic [31:0] psw;} dpa_note_t;
   logic        clk_in, reset_n_in, instr_valid_in, cond_pass_in, load_en_in;
   logic [31:0] instr_in, saved_status_word_in, load_data_in, psw, lfsr;
   logic [3:0]  load_index_in;
   wire         instr_ready_out, done_out, result_write_out, pc_write_out;
   wire [31:0]  result_out, program_status_word_out;
   wire [3:0]   result_index_out;
   logic [31:0] rf [16];
   logic [31:0] seedv [6] = '{32'h0, 32'h7FFFFFFF, 32'h80000000, 32'h20, 32'h21, 32'h100};
   int          error_cnt, tests_run;
   dpa_note_t   notes [$];
   dpa_note_t   e;
   dpa_datapath i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .cond_pass_in(cond_pass_in),
      .saved_status_word_in(saved_status_word_in),
      .load_en_in(load_en_in), .load_index_in(load_index_in), .load_data_in(load_data_in),
      .instr_ready_out(instr_ready_out), .done_out(done_out), .result_out(result_out),
      .result_write_out(result_write_out), .result_index_out(result_index_out),
      .pc_write_out(pc_write_out), .program_status_word_out(program_status_word_out));
   // Clock at 40 MHz
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   function automatic logic [31:0] rnd();
      repeat (32) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // Shifter reference: carry in bit 32
   function automatic logic [32:0] sh(input logic [31:0] m, input logic [1:0] t,
                                      input logic [7:0] n, input logic c);
      logic [63:0] x;
      x = 64'h0;
      if (n == 8'h00) return {c, m};
      case (t)
         2'h0: x = {32'h0, m} << n;
         2'h1: x = {m, 32'h0} >> n;
         2'h2: x = $signed({m, 32'h0}) >>> ((n > 8'h20) ? 8'h20 : n);
         default: x = {m, m} >> n[4:0];
      endcase
      if (t == 2'h0) return x[32:0];
      if (t == 2'h3) return {x[31], x[31:0]};
      return {x[31], x[63:32]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Reference model, note, drive, wait for done
   task automatic issue(input logic [31:0] ins, input logic cp);
      logic [3:0]  op, rd;
      logic [7:0]  n;
      logic [32:0] s2, sum;
      logic [31:0] a, b, x, y, r, sv;
      logic        c, cin, tst, lg, wr;
      int          k;
      op = ins[24:21];
      rd = ins[15:12];
      c = psw[`DPA_PSW_C];
      a = rf[ins[19:16]];
      tst = op[3:2] == 2'h2;
      sv = rnd();
      if (ins[25])
         s2 = sh({24'h0, ins[7:0]}, 2'h3, {3'h0, ins[11:8], 1'b0}, c);
      else
      begin
         n = ins[4] ? rf[ins[11:8]][7:0] : {3'h0, ins[11:7]};
         if (!ins[4] && n == 8'h00 && ins[6:5] != 2'h0) n = 8'h20;
         s2 = sh(rf[ins[3:0]], ins[6:5], n, c);
         if (!ins[4] && ins[11:7] == 5'h00 && ins[6:5] == 2'h3)
            s2 = {rf[ins[3:0]][0], c, rf[ins[3:0]][31:1]};
      end
      b = s2[31:0];
      x = a;
      y = b;
      cin = 1'b0;
      case (op)
         4'h2, 4'hA: {y, cin} = {~b, 1'b1};
         4'h3: {x, y, cin} = {b, ~a, 1'b1};
         4'h5: cin = c;
         4'h6: {y, cin} = {~b, c};
         4'h7: {x, y, cin} = {b, ~a, c};
         default: ;
      endcase
      sum = {1'b0, x} + {1'b0, y} + {32'h0, cin};
      case (op)
         4'h0, 4'h8: r = a & b;
         4'h1, 4'h9: r = a ^ b;
         4'hC: r = a | b;
         4'hD: r = b;
         4'hE: r = a & ~b;
         4'hF: r = ~b;
         default: r = sum[31:0];
      endcase
      lg = !(op inside {[4'h2:4'h7], 4'hA, 4'hB});
      wr = cp && !tst;
      if (wr && ins[20] && rd == `DPA_PC_INDEX) psw = sv;
      else if (cp && (ins[20] || tst))
         psw = {r[31], r == 32'h0, lg ? s2[32] : sum[32],
                lg ? psw[`DPA_PSW_V] : (x[31] == y[31] && r[31] != x[31]), psw[27:0]};
      if (wr) rf[rd] = r;
      notes.push_back('{r, wr, rd, wr && rd == `DPA_PC_INDEX, psw});
      chk(instr_ready_out, 1'b1);
      {instr_in, cond_pass_in, saved_status_word_in, instr_valid_in} = {ins, cp, sv, 1'b1};
      @(negedge clk_in);
      instr_valid_in = 1'b0;
      for (k = 0; k < 8 && done_out !== 1'b1; k++) @(negedge clk_in);
      chk(done_out, 1'b1);
      @(negedge clk_in);
   endtask
   // Random words over every opcode, both operand forms and failed conditions
   task automatic run(input int cnt);
      logic [31:0] w;
      for (int k = 0; k < cnt; k++)
      begin
         w = rnd();
         w[27:26] = 2'h0;
         w[24:21] = k[3:0];
         {w[19], w[11], w[3]} = {k[4], k[6], k[5]};
         if (w[4]) w[7] = 1'b0;
         if (w[15:12] < 4'h6) w[15] = 1'b1;
         issue(w, (k % 7) != 3);
      end
   endtask
   // Result watcher against the oldest note
   always @(negedge clk_in)
   begin
      if (reset_n_in === 1'b1 && done_out === 1'b1)
      begin
         if (notes.size() == 0) chk(1'b1, 1'b0);
         else
         begin
            e = notes.pop_front();
            chk(result_write_out, e.wr);
            chk(pc_write_out, e.pcw);
            chk(program_status_word_out, e.psw);
            if (e.wr) chk(result_out, e.res);
            if (e.wr) chk(result_index_out, e.idx);
         end
      end
   end
   // Watchdog
   initial
   begin
      #(25 * 20000);
      error_cnt++;
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      {reset_n_in, instr_valid_in, cond_pass_in, load_en_in} = 4'h0;
      {instr_in, saved_status_word_in, load_data_in, load_index_in} = 100'h0;
      lfsr = 32'h5EA64061;
      psw = `DPA_PSW_RESET;
      repeat (20) @(negedge clk_in);
      reset_n_in = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         load_en_in = 1'b1;
         load_index_in = i[3:0];
         load_data_in = (i < 6) ? seedv[i] : rnd();
         rf[i] = load_data_in;
         @(negedge clk_in);
      end
      load_en_in = 1'b0;
      run(128);
      reset_n_in = 1'b0;
      psw = `DPA_PSW_RESET;
      repeat (2) @(negedge clk_in);
      chk(program_status_word_out, `DPA_PSW_RESET);
      chk(instr_ready_out, 1'b1);
      reset_n_in = 1'b1;
      run(48);
      chk(notes.size(), 0);
      tally_and_finish();
   end
endmodule // dpa_datapath_tb_top
`default_nettype wire
